// file: verilog/shared_parallel_io_port.sv
/*
 * Shared parallel I/O port with APB register access.
 * Assumes APB master per protocol; pins asynchronous.
 */
// Register access over APB and the address map were chosen for this implementation.
// Operation
// - enabled driving peripheral owns the pin
// - idle enabled peripheral leaves pin to port
// - port output never loops into peripheral
// - direction one is input, zero output
// - reset sets every direction bit
// - latch register reads and writes latch
// - pin-level read pins, write latch
// - unimplemented bits read as zero, except in open-drain and converter config
// - open-drain bit drives low only
// - cleared config bit is analog, reset analog
// - analog if either converter selects it
// - analog pins read low on pin-level
// - disabled converter config bits ignored
`timescale 1ns/1ps
`default_nettype none

module shared_parallel_io_port
  import pio_port_pkg::*;
#(
  parameter int                    WIDTH       = PORT_WIDTH,
  parameter logic [PORT_WIDTH-1:0] IMPL_MASK   = 16'hffff,
  parameter logic [PORT_WIDTH-1:0] ANALOG_MASK = 16'h00ff
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  input  wire logic [WIDTH-1:0] periph_en,
  input  wire logic [WIDTH-1:0] periph_drive,
  input  wire logic [WIDTH-1:0] periph_out,
  output logic      [WIDTH-1:0] periph_in,
  output logic      [WIDTH-1:0] analog_sel
);

  // -------------------------------------------------------------------
  // register state
  // -------------------------------------------------------------------
  logic [WIDTH-1:0] pin_direction_reg;
  logic [WIDTH-1:0] output_latch_reg;
  logic [WIDTH-1:0] open_drain_select_reg;
  logic [WIDTH-1:0] first_converter_pin_config;
  logic [WIDTH-1:0] second_converter_pin_config;
  logic             first_converter_disable_bit;
  logic             second_converter_disable_bit;
  logic [WIDTH-1:0] pins_synced;
  logic [WIDTH-1:0] pin_level_reg;
  logic [WIDTH-1:0] impl;
  logic [WIDTH-1:0] ana;
  logic             acc_done;
  logic             wr_en;
  logic             known;
  logic [31:0]      next_prdata;
  access_t          access;

  assign impl = IMPL_MASK[WIDTH-1:0];
  assign ana  = ANALOG_MASK[WIDTH-1:0];

  // byte-lane merge of a 16-bit register
  function automatic logic [WIDTH-1:0] merge
  (
    input logic [WIDTH-1:0] old,
    input logic [31:0]      wd,
    input logic [3:0]       st
  );
    logic [WIDTH-1:0] r;
    r = old;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st[i/8])
      begin
        r[i] = wd[i];
      end
    end
    return r;
  endfunction : merge

  // -------------------------------------------------------------------
  // apb decode, zero wait states
  // -------------------------------------------------------------------
  assign pready   = 1'b1;
  assign acc_done = psel & penable;
  assign wr_en    = (access == ACC_WRITE);

  always_comb
  begin
    known = (paddr == OFF_DIRECTION) || (paddr == OFF_PIN_LEVEL) ||
            (paddr == OFF_LATCH) || (paddr == OFF_OPEN_DRAIN) ||
            (paddr == OFF_CONV1_CFG) || (paddr == OFF_CONV2_CFG) ||
            (paddr == OFF_CONV_DIS);
    if (!acc_done)
    begin
      access = ACC_IDLE;
    end
    else if (pwrite)
    begin
      access = ACC_WRITE;
    end
    else
    begin
      access = ACC_READ;
    end
  end

  assign pslverr = acc_done & ~known;

  // -------------------------------------------------------------------
  // direction register
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_direction_reg <= RST_DIRECTION[WIDTH-1:0];
    end
    else if (wr_en && paddr == OFF_DIRECTION)
    begin
      pin_direction_reg <= merge(pin_direction_reg, pwdata, pstrb);
    end
  end

  // -------------------------------------------------------------------
  // output latch, written through latch or pin-level address
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_latch_reg <= RST_LATCH[WIDTH-1:0];
    end
    else if (wr_en && (paddr == OFF_LATCH || paddr == OFF_PIN_LEVEL))
    begin
      output_latch_reg <= merge(output_latch_reg, pwdata, pstrb);
    end
  end

  // -------------------------------------------------------------------
  // open-drain select
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      open_drain_select_reg <= RST_OPEN_DRAIN[WIDTH-1:0];
    end
    else if (wr_en && paddr == OFF_OPEN_DRAIN)
    begin
      open_drain_select_reg <= merge(open_drain_select_reg, pwdata, pstrb);
    end
  end

  // -------------------------------------------------------------------
  // analog configuration, cleared (analog) after reset
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_converter_pin_config  <= RST_CONV_CFG[WIDTH-1:0];
      second_converter_pin_config <= RST_CONV_CFG[WIDTH-1:0];
    end
    else if (wr_en && paddr == OFF_CONV1_CFG)
    begin
      first_converter_pin_config <= merge(first_converter_pin_config,
                                          pwdata, pstrb);
    end
    else if (wr_en && paddr == OFF_CONV2_CFG)
    begin
      second_converter_pin_config <= merge(second_converter_pin_config,
                                           pwdata, pstrb);
    end
  end

  // converter module disable bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_converter_disable_bit  <= RST_CONV_DIS[FIRST_DIS_BIT];
      second_converter_disable_bit <= RST_CONV_DIS[SECOND_DIS_BIT];
    end
    else if (wr_en && paddr == OFF_CONV_DIS && pstrb[0])
    begin
      first_converter_disable_bit  <= pwdata[FIRST_DIS_BIT];
      second_converter_disable_bit <= pwdata[SECOND_DIS_BIT];
    end
  end

  // -------------------------------------------------------------------
  // analog selection per pin
  // -------------------------------------------------------------------
  always_comb
  begin
    analog_sel = ana &
      ((~first_converter_pin_config &
        {WIDTH{~first_converter_disable_bit}}) |
       (~second_converter_pin_config &
        {WIDTH{~second_converter_disable_bit}}));
  end

  // -------------------------------------------------------------------
  // pin synchroniser and output mux
  // -------------------------------------------------------------------
  pin_sync #(.WIDTH(WIDTH)) u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pins_synced)
  );

  pin_mux #(.WIDTH(WIDTH)) u_mux
  (
    .direction    (pin_direction_reg),
    .latch        (output_latch_reg),
    .open_drain   (open_drain_select_reg),
    .implemented  (impl),
    .periph_en    (periph_en),
    .periph_drive (periph_drive),
    .periph_out   (periph_out),
    .pin_in       (pin_in),
    .pin_out      (pin_out),
    .pin_oe       (pin_oe),
    .periph_in    (periph_in)
  );

  // analog pins and missing bits read low
  assign pin_level_reg = pins_synced & ~analog_sel & impl;

  // -------------------------------------------------------------------
  // read data mux, registered
  // -------------------------------------------------------------------
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      OFF_DIRECTION:  next_prdata[WIDTH-1:0] = pin_direction_reg & impl;
      OFF_PIN_LEVEL:  next_prdata[WIDTH-1:0] = pin_level_reg;
      OFF_LATCH:      next_prdata[WIDTH-1:0] = output_latch_reg & impl;
      OFF_OPEN_DRAIN: next_prdata[WIDTH-1:0] = open_drain_select_reg;
      OFF_CONV1_CFG:  next_prdata[WIDTH-1:0] = first_converter_pin_config;
      OFF_CONV2_CFG:  next_prdata[WIDTH-1:0] = second_converter_pin_config;
      OFF_CONV_DIS:
      begin
        next_prdata[FIRST_DIS_BIT]  = first_converter_disable_bit;
        next_prdata[SECOND_DIS_BIT] = second_converter_disable_bit;
      end
      default:        next_prdata = 32'h0000_0000;
    endcase
  end

  // capture read data in setup phase so it stands during access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= next_prdata;
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  dir_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> pin_direction_reg == RST_DIRECTION[WIDTH-1:0])
    else $error("direction not input after reset");

  owner_a: assert property (@(posedge pclk) disable iff (!presetn)
    (periph_en & periph_drive & ~open_drain_select_reg) != '0 |->
    ((pin_out ^ periph_out) & periph_en & periph_drive &
     ~open_drain_select_reg) == '0)
    else $error("peripheral lost pin ownership");

  port_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((~(periph_en & periph_drive) & ~pin_direction_reg & impl &
      ~open_drain_select_reg & ~pin_oe) == '0))
    else $error("port output not driven");

  input_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_direction_reg & ~(periph_en & periph_drive) & pin_oe) == '0))
    else $error("input pin driven");

  no_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((periph_in & ~(periph_en & periph_drive) &
      ~pin_direction_reg & impl) == '0))
    else $error("port output looped to peripheral");

  od_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((open_drain_select_reg & pin_oe & pin_out) == '0))
    else $error("open drain drove high");

  latch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFF_PIN_LEVEL && pstrb == 4'hf) |=>
    output_latch_reg == $past(pwdata[WIDTH-1:0]))
    else $error("pin-level write missed latch");

  analog_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == OFF_PIN_LEVEL |=>
    (prdata[WIDTH-1:0] & $past(analog_sel)) == '0)
    else $error("analog pin read high");

  conv_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_converter_disable_bit && second_converter_disable_bit |->
    analog_sel == '0)
    else $error("disabled converter kept analog");

  unimpl_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((pin_level_reg | pin_oe) & ~impl & ~(periph_en & periph_drive)) == '0)
    else $error("unimplemented bit active");

endmodule : shared_parallel_io_port
`default_nettype wire

// file: verilog/pio_port_pkg.sv
/*
 * Package for the shared parallel I/O port: register offsets, reset
 * values, field positions and APB access kinds.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
package pio_port_pkg;

  // -------------------------------------------------------------------
  // port geometry
  // -------------------------------------------------------------------
  localparam int PORT_WIDTH = 16;

  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFF_DIRECTION  = 8'h00;
  localparam logic [7:0] OFF_PIN_LEVEL  = 8'h04;
  localparam logic [7:0] OFF_LATCH      = 8'h08;
  localparam logic [7:0] OFF_OPEN_DRAIN = 8'h0c;
  localparam logic [7:0] OFF_CONV1_CFG  = 8'h10;
  localparam logic [7:0] OFF_CONV2_CFG  = 8'h14;
  localparam logic [7:0] OFF_CONV_DIS   = 8'h18;

  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [15:0] RST_DIRECTION  = 16'hffff;
  localparam logic [15:0] RST_LATCH      = 16'h0000;
  localparam logic [15:0] RST_OPEN_DRAIN = 16'h0000;
  localparam logic [15:0] RST_CONV_CFG   = 16'h0000;
  localparam logic [1:0]  RST_CONV_DIS   = 2'h0;

  // -------------------------------------------------------------------
  // converter disable field positions
  // -------------------------------------------------------------------
  localparam int FIRST_DIS_BIT  = 0;
  localparam int SECOND_DIS_BIT = 1;

  // -------------------------------------------------------------------
  // apb access kinds
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } access_t;

endpackage : pio_port_pkg

// file: verilog/pin_sync.sv
/*
 * Two-stage synchroniser for a vector of pin levels.
 * Assumes pins are asynchronous; only the second stage is used outside.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync
  import pio_port_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // -------------------------------------------------------------------
  // two flops in series
  // -------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : pin_sync
`default_nettype wire

// file: verilog/pin_mux.sv
/*
 * Per-pin output multiplexer: peripheral or port owns each pin driver,
 * open-drain shaping, and loop-through blocking on peripheral input.
 * Assumes peripheral enable/drive signals are synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_mux
  import pio_port_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
)
(
  input  wire logic [WIDTH-1:0] direction,
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] open_drain,
  input  wire logic [WIDTH-1:0] implemented,
  input  wire logic [WIDTH-1:0] periph_en,
  input  wire logic [WIDTH-1:0] periph_drive,
  input  wire logic [WIDTH-1:0] periph_out,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] periph_in
);

  logic [WIDTH-1:0] periph_owns;
  logic [WIDTH-1:0] port_drives;
  logic [WIDTH-1:0] raw_out;
  logic [WIDTH-1:0] raw_en;

  // -------------------------------------------------------------------
  // ownership and drive
  // -------------------------------------------------------------------
  always_comb
  begin
    periph_owns = periph_en & periph_drive;
    port_drives = ~periph_owns & ~direction & implemented;
    raw_en  = periph_owns | port_drives;
    raw_out = (periph_owns & periph_out) | (~periph_owns & latch);
    // open drain: drive only the low level, release the high
    pin_out = raw_out & ~open_drain;
    pin_oe  = raw_en & ~(open_drain & raw_out);
    // peripheral sees the pin only when the port is not driving it
    periph_in = pin_in & ~port_drives;
  end

endmodule : pin_mux
`default_nettype wire

// file: sim/pin_world.sv
/*
 * Far side of the port: external drivers and pull-ups on each pin.
 * Assumes the port's drive and enable settle combinationally.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_world
(
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] ext_oe,
  input  wire logic [15:0] ext_val,
  output logic      [15:0] pin_in
);
  // port first, then outside driver, else pull-up
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_oe[i])
        pin_in[i] = ext_val[i];
      else
        pin_in[i] = 1'b1;
    end
  end
endmodule : pin_world

`default_nettype wire

// file: sim/tb_shared_parallel_io_port.sv
/*
 * Self-checking bench for the shared parallel I/O port.
 * Assumes zero-wait APB slave and a two-edge pin synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_shared_parallel_io_port;
  import pio_port_pkg::*;

  typedef struct {logic [7:0] a; logic [31:0] wd, ex; logic er;} row_t;
  typedef struct {logic [15:0] c1, c2; logic [1:0] ds; logic [15:0] ex;} an_t;

  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr;
  logic [15:0] pin_in, pin_out, pin_oe, periph_in, analog_sel;
  logic [15:0] periph_en = 0, periph_drive = 0, periph_out = 0;
  logic [15:0] ext_oe = 0, ext_val = 0;
  int          fails = 0, checked = 0;

  // ---------------------------------------------------------------
  // clock, design and pins
  // ---------------------------------------------------------------
  always #20 pclk = ~pclk;

  shared_parallel_io_port #(.IMPL_MASK(16'h7fff), .ANALOG_MASK(16'h00ff))
  dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .periph_en(periph_en), .periph_drive(periph_drive),
    .periph_out(periph_out), .periph_in(periph_in),
    .analog_sel(analog_sel));

  pin_world world_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_oe(ext_oe),
    .ext_val(ext_val), .pin_in(pin_in));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a,
                    input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(n, x, r);
  endtask : rd

  // reset held for five cycles, then reset state checked
  task automatic reset_check();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("analog_sel", 32'h00ff, {16'h0, analog_sel});
    chk("pin_oe", 32'h0, {16'h0, pin_oe});
    rd("direction", OFF_DIRECTION, 32'h7fff);
    rd("latch", OFF_LATCH, 32'h0);
    rd("open_drain", OFF_OPEN_DRAIN, 32'h0);
  endtask : reset_check

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  row_t rows[7] = '{
    '{8'h08, 32'h0000a5a5, 32'h000025a5, 1'b0},
    '{8'h00, 32'hffff0f0f, 32'h00000f0f, 1'b0},
    '{8'h0c, 32'h000000ff, 32'h000000ff, 1'b0},
    '{8'h10, 32'h00007ff0, 32'h00007ff0, 1'b0},
    '{8'h14, 32'h00007f0f, 32'h00007f0f, 1'b0},
    '{8'h18, 32'h00000003, 32'h00000003, 1'b0},
    '{8'h1c, 32'h12345678, 32'h00000000, 1'b1}};
  an_t an[6] = '{
    '{16'h7fff, 16'h7fff, 2'd0, 16'h0000},
    '{16'h7ff0, 16'h7fff, 2'd0, 16'h000f},
    '{16'h7fff, 16'h7f0f, 2'd0, 16'h00f0},
    '{16'h7ff0, 16'h7f0f, 2'd1, 16'h00f0},
    '{16'h7ff0, 16'h7f0f, 2'd2, 16'h000f},
    '{16'h7ff0, 16'h7f0f, 2'd3, 16'h0000}};

  initial
  begin
    logic [31:0] r;
    logic        e;
    reset_check();
    // register rows: write, read back, slave error
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0, r, e);
      chk("row_data", rows[i].ex, r);
      chk("row_err", {31'h0, rows[i].er}, {31'h0, e});
    end
    // driven outputs; analog pins read low
    wr(OFF_CONV_DIS, 32'h0);
    wr(OFF_OPEN_DRAIN, 32'h0);
    wr(OFF_CONV1_CFG, 32'h0);
    wr(OFF_DIRECTION, 32'h0);
    wr(OFF_LATCH, 32'h1234);
    repeat (3) @(posedge pclk);
    chk("pin_oe", 32'h7fff, {16'h0, pin_oe});
    chk("pin_out", 32'h1234, {16'h0, pin_out & 16'h7fff});
    rd("pin_level", OFF_PIN_LEVEL, 32'h1200);
    wr(OFF_PIN_LEVEL, 32'h00ff);
    rd("latch", OFF_LATCH, 32'h00ff);
    // analog selection across both converters; inputs for analog
    wr(OFF_DIRECTION, 32'hffff);
    ext_oe  <= 16'hffff;
    ext_val <= 16'hffff;
    foreach (an[i])
    begin
      wr(OFF_CONV1_CFG, {16'h0, an[i].c1});
      wr(OFF_CONV2_CFG, {16'h0, an[i].c2});
      wr(OFF_CONV_DIS, {30'h0, an[i].ds});
      repeat (3) @(posedge pclk);
      chk("analog_sel", {16'h0, an[i].ex}, {16'h0, analog_sel});
      rd("pin_level", OFF_PIN_LEVEL, {17'h0, ~an[i].ex[14:0]});
    end
    // open drain: latch ones release, zeros pull low
    ext_oe <= 16'h0;
    wr(OFF_DIRECTION, 32'h0);
    wr(OFF_OPEN_DRAIN, 32'hffff);
    wr(OFF_LATCH, 32'h00ff);
    repeat (3) @(posedge pclk);
    chk("od_oe", 32'h7f00, {16'h0, pin_oe});
    chk("od_out", 32'h0, {16'h0, pin_out & pin_oe});
    rd("od_level", OFF_PIN_LEVEL, 32'h00ff);
    // peripheral owns its driven pins, port keeps the rest
    wr(OFF_OPEN_DRAIN, 32'h0);
    wr(OFF_LATCH, 32'h7ff0);
    periph_en    <= 16'hffff;
    periph_drive <= 16'h000f;
    periph_out   <= 16'h0005;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("per_oe", 32'h7fff, {16'h0, pin_oe});
    chk("per_out", 32'h7ff5, {16'h0, pin_out & 16'h7fff});
    chk("per_in", 32'h0, {16'h0, periph_in & 16'h7ff0});
    wr(OFF_DIRECTION, 32'hffff);
    repeat (3) @(posedge pclk);
    chk("per_oe_in", 32'h000f, {16'h0, pin_oe});
    rd("per_level", OFF_PIN_LEVEL, 32'h7ff5);
    // reset again in mid-run
    periph_en    <= 16'h0;
    periph_drive <= 16'h0;
    reset_check();
    conclude();
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    conclude();
  end
endmodule : tb_shared_parallel_io_port

`default_nettype wire
